// [logic/tfs_pkg.sv]
// Constants shared by the timer input filter select block.
// Assumes one system clock; all slower rates are enable pulses.
package tfs_pkg;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 4;
  localparam int CH_BIT = 3;
  localparam logic [2:0] IDX_COUNT = 3'h0;
  localparam logic [2:0] IDX_GRA = 3'h1;
  localparam logic [2:0] IDX_GRD = 3'h4;
  localparam logic [2:0] IDX_FILT = 3'h5;
  localparam int GR_NUM = 4;
  localparam int CH_NUM = 2;
  localparam int PIN_NUM = 4;

  // ==========================================================
  // Filter control layout
  localparam int FC_SEL_HI = 7;
  localparam int FC_SEL_LO = 6;
  localparam logic [7:0] FC_WRITE_MASK = 8'hcf;
  localparam logic [7:0] FC_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [1:0] SEL_DIV32 = 2'h0;
  localparam logic [1:0] SEL_DIV8 = 2'h1;
  localparam logic [1:0] SEL_SYS = 2'h2;
  localparam logic [1:0] SEL_PRESC = 2'h3;

  // ==========================================================
  // Clock division and filter depth
  localparam int DIV_FAST = 8;
  localparam int DIV_SLOW = 32;
  localparam logic [4:0] DIV_SLOW_LAST = 5'(DIV_SLOW - 1);
  localparam logic [2:0] DIV_FAST_LAST = 3'(DIV_FAST - 1);
  localparam int FILT_SAMPLES = 3;
  localparam logic [1:0] FILT_LAST = 2'(FILT_SAMPLES - 1);

endpackage

// [logic/tfs_pin_filter.sv]
// One capture/compare pin: synchroniser, then optional glitch filter.
// Assumes the sample tick is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
module tfs_pin_filter (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic pin_raw,
  input wire logic sample_tick,
  input wire logic filt_en,
  output logic pin_level
);

  logic sync1_reg;
  logic sync2_reg;
  logic [1:0] cnt_reg;
  logic level_reg;

  // ==========================================================
  // Synchroniser
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // Filter: a new level must hold over consecutive samples
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 2'h0;
      level_reg <= 1'b0;
    end else if (!filt_en) begin
      cnt_reg <= 2'h0;
      level_reg <= sync2_reg;
    end else if (sample_tick) begin
      if (sync2_reg == level_reg) begin
        cnt_reg <= 2'h0;
      end else if (cnt_reg == tfs_pkg::FILT_LAST) begin
        cnt_reg <= 2'h0;
        level_reg <= sync2_reg;
      end else begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
  end

  assign pin_level = level_reg;

  // ==========================================================
  // Checks
  property p_filter_hold;
    @(posedge ref_clk) disable iff (!resetn)
    (filt_en && $past(filt_en) && $changed(level_reg)) |->
      ($past(cnt_reg) == tfs_pkg::FILT_LAST) && $past(sample_tick);
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("Filtered level changed before enough samples");

endmodule

// [logic/tfs_top.sv]
// Timer input filter select: per-channel filter control, counter and
// general compare storage, and the eight filtered capture pins.
// Assumes the CPU port and prescaler ticks are on ref_clk; pins are async.
//
// Summary of operation
// - Filter clock: 00 sys/32, 01 sys/8, 10 sys, 11 prescaler clock.
// - Bits 5 and 4 of filter control are reserved and read zero.
// - Bit 3 enables the pin D filter, else bypass; resets to zero.
// - Bit 2 enables the pin C filter, else bypass; resets to zero.
// - Bit 1 enables the pin B filter, else bypass; resets to zero.
// - Bit 0 enables the pin A filter, else bypass; resets to zero.
// - Two filter control registers, each governs only its own channel.
// - Counter and general compare registers are 16-bit, word access only.
// - All other timer registers are byte registers on an 8-bit path.
// - A filter enable acts only while the pin is configured as input.
`timescale 1ns/100ps
module tfs_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic cpu_word,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  input wire logic [1:0] presc_tick,
  input wire logic [7:0] pin_raw,
  input wire logic [7:0] pin_is_input,
  output logic [7:0] pin_filtered
);

  logic [15:0] count_reg [tfs_pkg::CH_NUM];
  logic [15:0] gr_reg [tfs_pkg::CH_NUM][tfs_pkg::GR_NUM];
  logic [7:0] fc_reg [tfs_pkg::CH_NUM];
  logic [4:0] div_reg;
  logic [15:0] rdata_reg;
  logic tick_fast;
  logic tick_slow;
  logic [1:0] ch_tick;
  logic [7:0] en_eff;
  logic acc_ch;
  logic [2:0] acc_idx;
  logic is_gr;
  logic word_ok;
  logic byte_ok;

  function automatic logic pick_tick(input logic [1:0] sel, input logic t32,
                                     input logic t8, input logic tp);
    unique case (sel)
      tfs_pkg::SEL_DIV32: pick_tick = t32;
      tfs_pkg::SEL_DIV8: pick_tick = t8;
      tfs_pkg::SEL_SYS: pick_tick = 1'b1;
      tfs_pkg::SEL_PRESC: pick_tick = tp;
    endcase
  endfunction

  // ==========================================================
  // Access decode
  assign acc_ch = cpu_addr[tfs_pkg::CH_BIT];
  assign acc_idx = cpu_addr[2:0];
  assign is_gr = (acc_idx >= tfs_pkg::IDX_GRA) && (acc_idx <= tfs_pkg::IDX_GRD);
  // Word registers refuse byte access and the byte register refuses words
  assign word_ok = cpu_word && (is_gr || acc_idx == tfs_pkg::IDX_COUNT);
  assign byte_ok = !cpu_word && acc_idx == tfs_pkg::IDX_FILT;

  // ==========================================================
  // Filter sample clocks
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 5'h00;
    end else begin
      div_reg <= div_reg + 5'h01;
    end
  end

  assign tick_fast = div_reg[2:0] == tfs_pkg::DIV_FAST_LAST;
  assign tick_slow = div_reg == tfs_pkg::DIV_SLOW_LAST;

  always_comb begin
    for (int c = 0; c < tfs_pkg::CH_NUM; c++) begin
      ch_tick[c] = pick_tick(fc_reg[c][tfs_pkg::FC_SEL_HI:tfs_pkg::FC_SEL_LO],
                             tick_slow, tick_fast, presc_tick[c]);
    end
  end

  // ==========================================================
  // Filter control registers, one per channel
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fc_reg[0] <= tfs_pkg::FC_RESET;
      fc_reg[1] <= tfs_pkg::FC_RESET;
    end else if (cpu_wr && byte_ok) begin
      fc_reg[acc_ch] <= cpu_wdata[7:0] & tfs_pkg::FC_WRITE_MASK;
    end
  end

  // ==========================================================
  // Counter and general compare storage, whole words only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < tfs_pkg::CH_NUM; c++) begin
        count_reg[c] <= tfs_pkg::WORD_RESET;
      end
    end else begin
      for (int c = 0; c < tfs_pkg::CH_NUM; c++) begin
        // A CPU write wins over a count on the same edge
        if (cpu_wr && word_ok && acc_idx == tfs_pkg::IDX_COUNT && acc_ch == c) begin
          count_reg[c] <= cpu_wdata;
        end else if (presc_tick[c]) begin
          count_reg[c] <= count_reg[c] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < tfs_pkg::CH_NUM; c++) begin
        for (int g = 0; g < tfs_pkg::GR_NUM; g++) begin
          gr_reg[c][g] <= tfs_pkg::WORD_RESET;
        end
      end
    end else if (cpu_wr && word_ok && is_gr) begin
      gr_reg[acc_ch][2'(acc_idx - tfs_pkg::IDX_GRA)] <= cpu_wdata;
    end
  end

  // ==========================================================
  // Read data, one cycle after the read strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= tfs_pkg::WORD_RESET;
    end else if (cpu_rd) begin
      if (byte_ok) begin
        rdata_reg <= {8'h00, fc_reg[acc_ch] & tfs_pkg::FC_WRITE_MASK};
      end else if (word_ok && is_gr) begin
        rdata_reg <= gr_reg[acc_ch][2'(acc_idx - tfs_pkg::IDX_GRA)];
      end else if (word_ok) begin
        rdata_reg <= count_reg[acc_ch];
      end else begin
        rdata_reg <= tfs_pkg::WORD_RESET;
      end
    end
  end

  assign cpu_rdata = rdata_reg;

  // ==========================================================
  // Pin filters; enable counts only for pins set as inputs
  always_comb begin
    for (int p = 0; p < tfs_pkg::CH_NUM * tfs_pkg::PIN_NUM; p++) begin
      en_eff[p] = fc_reg[p / tfs_pkg::PIN_NUM][p % tfs_pkg::PIN_NUM]
                  && pin_is_input[p];
    end
  end

  for (genvar p = 0; p < tfs_pkg::CH_NUM * tfs_pkg::PIN_NUM; p++) begin : g_pin
    tfs_pin_filter u_filt (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pin_raw(pin_raw[p]),
      .sample_tick(ch_tick[p / tfs_pkg::PIN_NUM]),
      .filt_en(en_eff[p]),
      .pin_level(pin_filtered[p])
    );
  end

  // ==========================================================
  // Checks
  logic [1:0] ch0_sel;

  assign ch0_sel = fc_reg[0][tfs_pkg::FC_SEL_HI:tfs_pkg::FC_SEL_LO];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_filt_read;
    cpu_rd && !cpu_word && acc_idx == tfs_pkg::IDX_FILT;
  endsequence

  property p_reserved_zero;
    s_filt_read |=> cpu_rdata[5:4] == 2'h0 && cpu_rdata[15:8] == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved filter control bits read nonzero");

  property p_sel_sys;
    (ch0_sel == tfs_pkg::SEL_SYS) |-> ch_tick[0];
  endproperty
  a_sel_sys: assert property (p_sel_sys)
    else $error("Undivided filter clock not selected");

  // A reselect inside the quiet window may tick at once under the new source
  property p_sel_div8;
    (ch0_sel == tfs_pkg::SEL_DIV8 && ch_tick[0]) |=>
      (ch0_sel != tfs_pkg::SEL_DIV8 || !ch_tick[0]) [*7];
  endproperty
  a_sel_div8: assert property (p_sel_div8)
    else $error("Divide by 8 filter clock spacing wrong");

  property p_bypass_a;
    (!en_eff[0]) [*3] |-> pin_filtered[0] == $past(pin_raw[0], 3);
  endproperty
  a_bypass_a: assert property (p_bypass_a)
    else $error("Pin A not bypassed");

  property p_bypass_b;
    (!en_eff[1]) [*3] |-> pin_filtered[1] == $past(pin_raw[1], 3);
  endproperty
  a_bypass_b: assert property (p_bypass_b)
    else $error("Pin B not bypassed");

  property p_bypass_c;
    (!en_eff[2]) [*3] |-> pin_filtered[2] == $past(pin_raw[2], 3);
  endproperty
  a_bypass_c: assert property (p_bypass_c)
    else $error("Pin C not bypassed");

  property p_bypass_d;
    (!en_eff[7]) [*3] |-> pin_filtered[7] == $past(pin_raw[7], 3);
  endproperty
  a_bypass_d: assert property (p_bypass_d)
    else $error("Pin D not bypassed");

  property p_output_pin;
    (!pin_is_input[0]) [*3] |-> pin_filtered[0] == $past(pin_raw[0], 3);
  endproperty
  a_output_pin: assert property (p_output_pin)
    else $error("Filter acted on a pin not set as input");

  property p_ch_isolate;
    (cpu_wr && !acc_ch) |=> $stable(fc_reg[1]);
  endproperty
  a_ch_isolate: assert property (p_ch_isolate)
    else $error("Channel 0 write changed channel 1 filter control");

  property p_gr_word_only;
    (cpu_wr && !cpu_word && acc_idx == tfs_pkg::IDX_GRA && !acc_ch) |=> $stable(gr_reg[0][0]);
  endproperty
  a_gr_word_only: assert property (p_gr_word_only)
    else $error("Byte write changed a compare register");

  property p_fc_byte_only;
    (cpu_wr && cpu_word) |=> $stable(fc_reg[0]) && $stable(fc_reg[1]);
  endproperty
  a_fc_byte_only: assert property (p_fc_byte_only)
    else $error("Word write changed a filter control register");

endmodule

// [bench/tfs_cpu_model.sv]
// CPU side of the timer register port: one strobe per transfer.
// Assumes read data is registered at the taking edge and valid by the next falling edge.
`timescale 1ns/100ps
module tfs_cpu_model (
  input wire logic ref_clk,
  output logic [3:0] cpu_addr,
  output logic cpu_wr,
  output logic cpu_rd,
  output logic cpu_word,
  output logic [15:0] cpu_wdata,
  input wire logic [15:0] cpu_rdata
);
  initial begin
    cpu_addr = 4'h0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_word = 1'b1;
    cpu_wdata = 16'h0000;
  end

  // ==========================================================
  // One transfer, launched and closed at falling edges
  task automatic access(input logic wr, input logic [3:0] a, input logic word,
                        input logic [15:0] d, output logic [15:0] q);
    @(negedge ref_clk);
    cpu_addr = a;
    cpu_word = word;
    cpu_wdata = d;
    cpu_wr = wr;
    cpu_rd = !wr;
    @(negedge ref_clk);
    q = cpu_rdata;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    // Released data lines show no stale value
    cpu_wdata = ~d;
  endtask
endmodule

// [bench/test_timer_input_filter_select.sv]
// Self-checking bench for the timer input filter select block.
// Assumes the CPU model drives the register port; pins driven here.
`timescale 1ns/100ps
module test_timer_input_filter_select;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] cpu_addr;
  logic cpu_wr;
  logic cpu_rd;
  logic cpu_word;
  logic [15:0] cpu_wdata;
  logic [15:0] cpu_rdata;
  logic [1:0] presc_tick = 2'h0;
  logic [7:0] pin_raw = 8'h00;
  logic [7:0] pin_is_input = 8'hff;
  logic [7:0] pin_filtered;
  logic [15:0] q;
  logic [1:0] pdiv = 2'h0;
  logic presc_on = 1'b1;
  logic seen;
  int err_count = 0;
  int n_compared = 0;
  int n;
  int div_tab [4] = '{32, 8, 1, 4};

  always #4 ref_clk = ~ref_clk;

  // Prescaler clock: one pulse every four cycles on both channels while on
  always @(negedge ref_clk) begin
    pdiv <= pdiv + 2'h1;
    presc_tick <= {2{pdiv == 2'h3 && presc_on}};
  end

  tfs_cpu_model u_cpu (.ref_clk(ref_clk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_word(cpu_word), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));

  tfs_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_word(cpu_word), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .presc_tick(presc_tick), .pin_raw(pin_raw),
    .pin_is_input(pin_is_input), .pin_filtered(pin_filtered));

  // ==========================================================
  // Shared tasks
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic ch, input logic [2:0] idx, input logic word,
                    input logic [15:0] d);
    u_cpu.access(1'b1, {ch, idx}, word, d, q);
  endtask

  task automatic rd_chk(input logic ch, input logic [2:0] idx, input logic word,
                        input logic [15:0] exp);
    u_cpu.access(1'b0, {ch, idx}, word, 16'h0000, q);
    chk(q, exp);
  endtask

  // Pulse one pin for w cycles and report whether it reached the output
  task automatic glitch(input int p, input int w, input logic exp);
    seen = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(negedge ref_clk);
      pin_raw[p] = (i < w);
      seen = seen | (pin_filtered[p] === 1'b1);
    end
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    rd_chk(1'b0, tfs_pkg::IDX_FILT, 1'b0, 16'h0000);
    rd_chk(1'b1, tfs_pkg::IDX_FILT, 1'b0, 16'h0000);
    rd_chk(1'b0, tfs_pkg::IDX_GRA, 1'b1, 16'h0000);
    wr(1'b0, tfs_pkg::IDX_FILT, 1'b0, 16'h00ff);
    rd_chk(1'b0, tfs_pkg::IDX_FILT, 1'b0, 16'h00cf);
    rd_chk(1'b1, tfs_pkg::IDX_FILT, 1'b0, 16'h0000);
    rd_chk(1'b0, tfs_pkg::IDX_FILT, 1'b1, 16'h0000);
    rd_chk(1'b0, 3'h6, 1'b0, 16'h0000);
    for (int i = 1; i <= 4; i++) begin
      wr(i[0], 3'(i), 1'b1, 16'ha500 + 16'(i));
      wr(i[0], 3'(i), 1'b0, 16'h00ff);
      rd_chk(i[0], 3'(i), 1'b1, 16'ha500 + 16'(i));
      rd_chk(i[0], 3'(i), 1'b0, 16'h0000);
    end
    wr(1'b0, tfs_pkg::IDX_GRA, 1'b1, 16'h5a01);
    wr(1'b0, tfs_pkg::IDX_GRA, 1'b0, 16'h00ff);
    rd_chk(1'b0, tfs_pkg::IDX_GRA, 1'b1, 16'h5a01);
    // Counter: prescaler stopped so the written word reads back exactly
    presc_on <= 1'b0;
    wr(1'b0, tfs_pkg::IDX_COUNT, 1'b1, 16'hfffe);
    rd_chk(1'b0, tfs_pkg::IDX_COUNT, 1'b1, 16'hfffe);
    wr(1'b0, tfs_pkg::IDX_COUNT, 1'b0, 16'h0012);
    rd_chk(1'b0, tfs_pkg::IDX_COUNT, 1'b1, 16'hfffe);
    // Sixteen cycles of prescaler give four ticks, wrapping past the top
    presc_on <= 1'b1;
    repeat (16) @(negedge ref_clk);
    presc_on <= 1'b0;
    repeat (2) @(negedge ref_clk);
    rd_chk(1'b0, tfs_pkg::IDX_COUNT, 1'b1, 16'h0002);
    presc_on <= 1'b1;
    $display("test registers done");
    // Each enable bit filters its own pin only; sampling every cycle
    for (int p = 0; p < 4; p++) begin
      wr(1'b0, tfs_pkg::IDX_FILT, 1'b0, 16'h0080 | (16'h0001 << p));
      glitch(p, 2, 1'b0);
      glitch(p, 4, 1'b1);
      glitch((p + 1) % 4, 2, 1'b1);
    end
    wr(1'b0, tfs_pkg::IDX_FILT, 1'b0, 16'h008f);
    glitch(4, 2, 1'b1);
    wr(1'b1, tfs_pkg::IDX_FILT, 1'b0, 16'h008f);
    glitch(4, 2, 1'b0);
    pin_is_input[0] = 1'b0;
    glitch(0, 2, 1'b1);
    pin_is_input[0] = 1'b1;
    $display("test enables done");
    // Delay through the filter scales with the selected sample clock
    for (int s = 0; s < 4; s++) begin
      wr(1'b0, tfs_pkg::IDX_FILT, 1'b0, {8'h00, 2'(s), 6'h01});
      pin_raw[0] = 1'b1;
      n = 0;
      while (pin_filtered[0] !== 1'b1 && n < 300) begin
        @(negedge ref_clk);
        n++;
      end
      chk(16'(n > 2 * div_tab[s] && n <= 3 * div_tab[s] + 6), 16'h0001);
      if (n >= 300) begin
        complete_run();
      end
      pin_raw[0] = 1'b0;
      repeat (3 * div_tab[s] + 8) @(negedge ref_clk);
    end
    $display("test clock select done");
    complete_run();
  end
endmodule
